// >>> rtl/lpu_pkg.sv
// lpu_pkg: register map, field layout and timing constants of the wake receiver
// assumes: used by every file of the block but lpu_sync as lpu_pkg::name, never imported
package lpu_pkg;

  // register word addresses (byte offsets, 32-bit aligned)
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_HOLDING = 8'h0c;
  localparam logic [7:0] ADDR_VERSION = 8'h20;

  // control bits
  localparam int CTRL_ON_BIT  = 0;
  localparam int CTRL_OFF_BIT = 1;

  // configuration fields
  localparam int CFG_SRC_LSB   = 0;
  localparam int CFG_ACTION_BIT = 2;
  localparam int CFG_MATCH_LSB = 8;

  // status bits
  localparam int STAT_EN_BIT    = 0;
  localparam int STAT_READY_BIT = 1;

  // reset values
  localparam logic [1:0]  SRC_RESET    = 2'h0;
  localparam logic [7:0]  MATCH_RESET  = 8'h00;
  localparam logic [31:0] VERSION_CODE = 32'h0000_0a5a; // arbitrary value

  // wake/event source selection
  typedef enum logic [1:0] {
    LPU_SRC_OFF   = 2'h0,
    LPU_SRC_START = 2'h1,
    LPU_SRC_FRAME = 2'h2,
    LPU_SRC_MATCH = 2'h3
  } lpu_src_e;

  // bit timing: baud over slow clock rate, accumulated as a fraction
  localparam int BAUD_HZ     = 9600;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int ACC_W       = 16;
  localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(SLOW_CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(BAUD_HZ);
  // half-bit preload puts the sample point near each bit centre
  localparam logic [ACC_W-1:0] ACC_HALF = ACC_W'(SLOW_CLK_HZ / 2);
  localparam int DATA_BITS = 8;

endpackage

// >>> rtl/lpu_sync.sv
// lpu_sync: two-flop synchroniser for a level from outside the clock domain
// assumes: first flop is read only by the second
`timescale 1ns/1ps
module lpu_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // level
  input  wire logic i_d,
  output logic      o_q
);

  logic meta_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RESET_VAL;
      o_q      <= RESET_VAL;
    end else if (i_ce) begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule

// >>> rtl/lpu_bit_timer.sv
// lpu_bit_timer: fractional accumulator giving one tick per serial bit period
// assumes: runs on the slow running clock; i_restart at the start edge
`timescale 1ns/1ps
module lpu_bit_timer (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // control
  input  wire logic i_run,
  input  wire logic i_restart,
  output logic      o_tick
);

  logic [lpu_pkg::ACC_W-1:0] acc_reg;
  logic [lpu_pkg::ACC_W:0]   sum;

  assign sum    = {1'b0, acc_reg} + {1'b0, lpu_pkg::ACC_STEP};
  assign o_tick = i_run && !i_restart && (sum[lpu_pkg::ACC_W-1:0] >= lpu_pkg::ACC_MOD);

  // bit period is about 3.4 clocks, so the remainder carries over each bit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= '0;
    end else if (i_ce) begin
      if (i_restart) begin
        // the start edge arrives two clocks late through the synchroniser;
        // one extra step of head start pulls every sample back to the centre
        acc_reg <= lpu_pkg::ACC_HALF + lpu_pkg::ACC_STEP;
      end else if (i_run) begin
        if (o_tick) begin
          acc_reg <= sum[lpu_pkg::ACC_W-1:0] - lpu_pkg::ACC_MOD;
        end else begin
          acc_reg <= sum[lpu_pkg::ACC_W-1:0];
        end
      end
    end
  end

endmodule

// >>> rtl/lpu_rx_top.sv
// lpu_rx_top: low-power receive-only serial wake receiver with register port
// assumes: i_clk is the slow running clock; serial line is asynchronous to it
//
// Function
// - sample line on slow clock, 9600 baud
// - frame: start, eight data LSB first, stop
// - discard frames not matching format
// - store valid byte in holding register
// - set ready flag when byte stored
// - clear ready flag on new start bit
// - no overrun detection; byte valid while ready
// - on command enables, off command disables
// - wake request usable from every power mode
// - start source: wake at start, keep receiving
// - frame source: store, flag, then wake
// - match source: wake only on matching byte
// - one source selection active at once
// - event action pulses event on same conditions
// - keeps running when bus clock gated
// - decoding runs from slow running clock
// - serial input wired straight to receiver
// - source code: off, start, frame, match
// - action zero wakes, one raises event
// - enable status bit mirrors receiver enable
`timescale 1ns/1ps
module lpu_rx_top (
  // clock, reset, clock enable
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  // serial line
  input  wire logic        i_rx_serial,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic [31:0]      o_rdata,
  // wake and event
  output logic             o_wake,
  output logic             o_event
);

  ////////////////////////////////////////////////////////////////////////////
  // serial input synchroniser

  logic rx_sync;

  // the pin feeds the receiver with no pin-mux stage in between
  lpu_sync #(
    .RESET_VAL (1'b1)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_d     (i_rx_serial),
    .o_q     (rx_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic       rx_enabled_reg;
  logic [1:0] src_reg;
  logic       action_reg;
  logic [7:0] match_reg;
  logic       wr_ctrl;
  logic       wr_cfg;

  assign wr_ctrl = i_wr && (i_addr == lpu_pkg::ADDR_CTRL);
  assign wr_cfg  = i_wr && (i_addr == lpu_pkg::ADDR_CONFIG);

  // off wins when both command bits are written together
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_enabled_reg <= 1'b0;
    end else if (i_ce && wr_ctrl) begin
      if (i_wdata[lpu_pkg::CTRL_OFF_BIT]) begin
        rx_enabled_reg <= 1'b0;
      end else if (i_wdata[lpu_pkg::CTRL_ON_BIT]) begin
        rx_enabled_reg <= 1'b1;
      end
    end
  end

  // writing while enabled is accepted; the result is undefined by design
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      src_reg    <= lpu_pkg::SRC_RESET;
      action_reg <= 1'b0;
      match_reg  <= lpu_pkg::MATCH_RESET;
    end else if (i_ce && wr_cfg) begin
      src_reg    <= i_wdata[lpu_pkg::CFG_SRC_LSB +: 2];
      action_reg <= i_wdata[lpu_pkg::CFG_ACTION_BIT];
      match_reg  <= i_wdata[lpu_pkg::CFG_MATCH_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive state machine

  typedef enum logic [1:0] {
    LPU_IDLE  = 2'b00,
    LPU_START = 2'b01,
    LPU_DATA  = 2'b11,
    LPU_STOP  = 2'b10
  } lpu_state_e;

  lpu_state_e state_reg;
  logic       rx_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte_value;
  logic       rx_byte_ready;
  logic       start_seen;
  logic       frame_ok;
  logic       tick;
  logic       timer_run;

  // falling edge while idle marks a start bit
  assign start_seen = rx_enabled_reg && (state_reg == LPU_IDLE) && rx_prev_reg
                      && !rx_sync;
  assign timer_run  = (state_reg != LPU_IDLE);

  lpu_bit_timer u_timer (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_run     (timer_run),
    .i_restart (start_seen),
    .o_tick    (tick)
  );

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_prev_reg <= 1'b1;
    end else if (i_ce) begin
      rx_prev_reg <= rx_sync;
    end
  end

  assign frame_ok = (state_reg == LPU_STOP) && tick && rx_sync;

  // all decoding lives on the slow clock, so a gated bus clock costs nothing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= LPU_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (i_ce) begin
      if (!rx_enabled_reg) begin
        state_reg <= LPU_IDLE;
      end else begin
        case (state_reg)
          LPU_IDLE: begin
            if (start_seen) begin
              state_reg <= LPU_START;
            end
          end
          LPU_START: begin
            // a start that is high at its centre was a glitch
            if (tick) begin
              if (rx_sync) begin
                state_reg <= LPU_IDLE;
              end else begin
                state_reg   <= LPU_DATA;
                bit_cnt_reg <= 3'h0;
              end
            end
          end
          LPU_DATA: begin
            if (tick) begin
              shift_reg   <= {rx_sync, shift_reg[7:1]};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'(lpu_pkg::DATA_BITS - 1)) begin
                state_reg <= LPU_STOP;
              end
            end
          end
          LPU_STOP: begin
            if (tick) begin
              state_reg <= LPU_IDLE;
            end
          end
          default: begin
            state_reg <= LPU_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // holding register and ready flag

  // no overrun flag: a new frame silently replaces the old byte
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_byte_value <= 8'h00;
    end else if (i_ce && frame_ok) begin
      rx_byte_value <= shift_reg;
    end
  end

  // start and frame end cannot fall in one cycle: start needs the idle state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_byte_ready <= 1'b0;
    end else if (i_ce) begin
      if (frame_ok) begin
        rx_byte_ready <= 1'b1;
      end else if (start_seen) begin
        rx_byte_ready <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake and event

  logic trigger;
  logic match_hit;

  // frame and match triggers follow the store, one cycle after the byte lands
  logic frame_done_reg;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frame_done_reg <= 1'b0;
    end else if (i_ce) begin
      frame_done_reg <= frame_ok;
    end
  end

  assign match_hit = frame_done_reg && (rx_byte_value == match_reg);

  always_comb begin
    case (lpu_pkg::lpu_src_e'(src_reg))
      lpu_pkg::LPU_SRC_START: trigger = start_seen;
      lpu_pkg::LPU_SRC_FRAME: trigger = frame_done_reg;
      lpu_pkg::LPU_SRC_MATCH: trigger = match_hit;
      default:                trigger = 1'b0;
    endcase
  end

  // a frame that ends just after a disable must not pulse a disabled receiver
  logic trigger_live;

  assign trigger_live = trigger && rx_enabled_reg;

  // outputs are plain pulses; the power manager decides what a wake means
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake  <= 1'b0;
      o_event <= 1'b0;
    end else if (i_ce) begin
      o_wake  <= trigger_live && !action_reg;
      o_event <= trigger_live && action_reg;
    end else begin
      o_wake  <= 1'b0;
      o_event <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_ce) begin
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          lpu_pkg::ADDR_CONFIG: begin
            o_rdata[lpu_pkg::CFG_SRC_LSB +: 2]   <= src_reg;
            o_rdata[lpu_pkg::CFG_ACTION_BIT]     <= action_reg;
            o_rdata[lpu_pkg::CFG_MATCH_LSB +: 8] <= match_reg;
          end
          lpu_pkg::ADDR_STATUS: begin
            o_rdata[lpu_pkg::STAT_EN_BIT]    <= rx_enabled_reg;
            o_rdata[lpu_pkg::STAT_READY_BIT] <= rx_byte_ready;
          end
          lpu_pkg::ADDR_HOLDING: begin
            o_rdata[7:0] <= rx_byte_value;
          end
          lpu_pkg::ADDR_VERSION: begin
            o_rdata <= lpu_pkg::VERSION_CODE;
          end
          default: begin
            o_rdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // byte path, bit counter and read mux are sized for an eight-bit frame
  if (lpu_pkg::DATA_BITS != 8) begin : g_chk_bits
    $error("receiver is built for eight data bits only");
  end

  // a baud rate at or above the clock rate would need two ticks in one cycle
  if (lpu_pkg::BAUD_HZ >= lpu_pkg::SLOW_CLK_HZ) begin : g_chk_rate
    $error("baud rate must stay below the running clock rate");
  end

  // the accumulator must hold the modulus plus one step without wrapping
  if (lpu_pkg::SLOW_CLK_HZ + lpu_pkg::BAUD_HZ >= (1 << lpu_pkg::ACC_W)) begin : g_chk_acc
    $error("bit timer accumulator too narrow for this clock rate");
  end

  // under three clocks per bit the synchroniser delay eats the sample margin
  if (3 * lpu_pkg::BAUD_HZ > lpu_pkg::SLOW_CLK_HZ) begin : g_chk_margin
    $error("running clock too slow to sample bit centres");
  end

  // configuration fields must neither overlap nor leave the word
  if ((lpu_pkg::CFG_SRC_LSB + 2 > lpu_pkg::CFG_ACTION_BIT)
      || (lpu_pkg::CFG_ACTION_BIT >= lpu_pkg::CFG_MATCH_LSB)
      || (lpu_pkg::CFG_MATCH_LSB + 8 > 32)) begin : g_chk_cfg
    $error("configuration fields overlap or leave the word");
  end

  // enable and ready flags share the status word and need a bit each
  if (lpu_pkg::STAT_EN_BIT == lpu_pkg::STAT_READY_BIT) begin : g_chk_stat
    $error("status bits collide");
  end

  // off needs its own bit so that it can win over on
  if (lpu_pkg::CTRL_ON_BIT == lpu_pkg::CTRL_OFF_BIT) begin : g_chk_ctrl
    $error("control command bits collide");
  end

endmodule

// >>> bench/lpu_rx_asserts.sv
// lpu_rx_asserts: port-level properties of the slow serial wake receiver
// assumes: bound to lpu_rx_top; register accesses count only with i_ce high
`timescale 1ns/1ps
module lpu_rx_asserts (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_ce,
  // serial line and register port
  input wire logic        i_rx_serial,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // wake and event
  input wire logic        o_wake,
  input wire logic        o_event
);
  logic       en_reg;
  logic [2:0] cfg_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////
  // shadow of enable and source/action; off wins over on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_reg <= 1'b0;
    end else if (i_ce && i_wr && i_addr == lpu_pkg::ADDR_CTRL) begin
      en_reg <= !i_wdata[1] && (i_wdata[0] || en_reg);
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= 3'h0;
    end else if (i_ce && i_wr && i_addr == lpu_pkg::ADDR_CONFIG) begin
      cfg_reg <= i_wdata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(i_rd && i_ce) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read slot");
  AST_CTRL_RD: assert property ($past(i_rd && i_ce && i_addr == lpu_pkg::ADDR_CTRL)
    |-> o_rdata == 32'h0) else $error("control word read not zero");
  AST_EN_STAT: assert property ($past(i_rd && i_ce && i_addr == lpu_pkg::ADDR_STATUS)
    |-> o_rdata[0] == $past(en_reg)) else $error("enable status wrong");
  AST_WAKE_PULSE: assert property (o_wake |=> !o_wake)
    else $error("wake longer than one cycle");
  AST_EVENT_PULSE: assert property (o_event |=> !o_event)
    else $error("event longer than one cycle");
  AST_ONE_OUT: assert property (!(o_wake && o_event))
    else $error("wake and event together");
  AST_CE_QUIET: assert property (!i_ce |=> !o_wake && !o_event)
    else $error("pulse while clock enable low");
  AST_WAKE_ROUTE: assert property (o_wake |-> en_reg && !cfg_reg[2] && cfg_reg[1:0] != 2'h0)
    else $error("wake without wake action");
  AST_EVENT_ROUTE: assert property (o_event |-> en_reg && cfg_reg[2] && cfg_reg[1:0] != 2'h0)
    else $error("event without event action");
  cover property (o_wake);
  cover property (o_event);
  cover property ($past(i_rd && i_addr == lpu_pkg::ADDR_STATUS) && o_rdata[1]);
endmodule
bind lpu_rx_top lpu_rx_asserts chk_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
  .i_rx_serial(i_rx_serial), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_wake(o_wake), .o_event(o_event));

// >>> bench/lpu_tx_model.sv
// lpu_tx_model: remote asynchronous transmitter on the receive line
// assumes: line idles high as with a pull-up; bit time scaled to the 40 ns clock
`timescale 1ns/1ps
module lpu_tx_model #(
  parameter real BIT_NS = 40.0 * 32768.0 / 9600.0
) (
  output logic o_line
);
  initial o_line = 1'b1;
  ////////////////////////////////////////////////////////////////
  // stop_ok low breaks the stop bit; gap sets how slowly frames follow
  task automatic send(input logic [7:0] b, input logic stop_ok, input int gap);
    o_line = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++) begin
      o_line = b[i];
      #(BIT_NS);
    end
    o_line = stop_ok;
    #(BIT_NS);
    o_line = 1'b1;
    #(BIT_NS * gap);
  endtask
endmodule

// >>> bench/tb_top.sv
// tb_top: self-checking bench for the slow serial wake receiver
// assumes: partner bit time follows the same clock scaling as the design
`timescale 1ns/1ps
module tb_top;
  logic        i_clk;
  logic        i_rst_n;
  logic        i_ce;
  logic        i_rx_serial;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        o_wake;
  logic        o_event;
  int          n_mismatch;
  int          n_compared;
  int          n_wake;
  int          n_event;
  logic [31:0] rv;
  logic [7:0]  hold_b;
  lpu_rx_top dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_rx_serial(i_rx_serial),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_wake(o_wake), .o_event(o_event));
  lpu_tx_model tx_u (.o_line(i_rx_serial));
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (o_wake === 1'b1) n_wake++;
    if (o_event === 1'b1) n_event++;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(what, exp, o_rdata);
  endtask
  // configure while off, enable, send one frame, then judge flag, byte and pulses
  task automatic frame(input logic [2:0] cfg, input logic [7:0] mt, input logic [7:0] b,
                       input logic ok, input int exp_n);
    int w0;
    int e0;
    wr(lpu_pkg::ADDR_CTRL, 32'h2);
    wr(lpu_pkg::ADDR_CONFIG, {16'h0, mt, 5'h0, cfg});
    wr(lpu_pkg::ADDR_CTRL, 32'h1);
    w0 = n_wake;
    e0 = n_event;
    tx_u.send(b, ok, 2);
    repeat (12) @(posedge i_clk);
    if (ok) hold_b = b;
    rchk("status", lpu_pkg::ADDR_STATUS, {30'h0, ok, 1'b1});
    rchk("holding", lpu_pkg::ADDR_HOLDING, {24'h0, hold_b});
    chk("wake", 32'(cfg[2] ? 0 : exp_n), 32'(n_wake - w0));
    chk("event", 32'(cfg[2] ? exp_n : 0), 32'(n_event - e0));
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rchk("status", lpu_pkg::ADDR_STATUS, 32'h0);
    rchk("config", lpu_pkg::ADDR_CONFIG, 32'h0);
    rchk("holding", lpu_pkg::ADDR_HOLDING, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rchk("unmapped", 8'h10, 32'h0);
    wr(lpu_pkg::ADDR_CONFIG, 32'hffff_ffff);
    rchk("config", lpu_pkg::ADDR_CONFIG, 32'h0000_ff07);
    wr(lpu_pkg::ADDR_CTRL, 32'h1);
    rchk("status", lpu_pkg::ADDR_STATUS, 32'h1);
    rchk("control", lpu_pkg::ADDR_CTRL, 32'h0);
    wr(lpu_pkg::ADDR_CTRL, 32'h3);
    rchk("status", lpu_pkg::ADDR_STATUS, 32'h0);
  endtask
  // every source under both actions; the loop matches only under event action, the last frame matches under wake action
  task automatic t_src();
    for (int a = 0; a < 2; a++) begin
      for (int s = 0; s < 4; s++) begin
        frame(3'(a * 4 + s), a ? 8'(8'h81 + 16 * s + a) : 8'h00, 8'(8'h81 + 16 * s + a),
              1'b1, s == 0 ? 0 : (s == 3 ? a : 1));
      end
    end
    frame(3'h3, 8'h5a, 8'h5a, 1'b1, 1);
  endtask
  // broken stop: start still pulses, nothing stored, start clears the flag and it stays clear
  task automatic t_bad();
    frame(3'h1, 8'h00, 8'h0f, 1'b0, 1);
    frame(3'h6, 8'h00, 8'hf0, 1'b0, 0);
  endtask
  task automatic t_off();
    int w0;
    wr(lpu_pkg::ADDR_CTRL, 32'h2);
    wr(lpu_pkg::ADDR_CONFIG, 32'h1);
    w0 = n_wake;
    tx_u.send(8'h77, 1'b1, 0);
    repeat (12) @(posedge i_clk);
    rchk("holding", lpu_pkg::ADDR_HOLDING, {24'h0, hold_b});
    chk("wake", 32'h0, 32'(n_wake - w0));
  endtask
  task automatic t_ce();
    @(posedge i_clk) i_ce <= 1'b0;
    wr(lpu_pkg::ADDR_CONFIG, 32'h5);
    @(posedge i_clk) i_ce <= 1'b1;
    rchk("config", lpu_pkg::ADDR_CONFIG, 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_addr = 8'h0;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    hold_b = 8'h0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_src();
    t_bad();
    t_off();
    t_ce();
    tally_and_finish();
  end
  // about eight times the expected run
  initial begin
    #250000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
